// >>> rtl/ucic_consts.svh
// constants for the uart control and interrupt configuration block
`ifndef UCIC_CONSTS_SVH
`define UCIC_CONSTS_SVH
`define UCIC_OFF_CTRL 12'h030
`define UCIC_OFF_TRIG 12'h034
`define UCIC_OFF_MASK 12'h038
`define UCIC_OFF_STAT 12'h03C
`define UCIC_BIT_RXEN 9
`define UCIC_BIT_TXEN 8
`define UCIC_BIT_LOOP 7
`define UCIC_BIT_MASTER 0
`define UCIC_POS_RXTRIG 3
`define UCIC_POS_TXTRIG 0
`define UCIC_POS_IRQ 4
`define UCIC_RST_RXEN 1'b1
`define UCIC_RST_TXEN 1'b1
`define UCIC_RST_LOOP 1'b0
`define UCIC_RST_MASTER 1'b0
`define UCIC_RST_TRIG 3'h2
`define UCIC_RST_MASK 7'h00
`define UCIC_LINE_IDLE 1'b1
`endif

// >>> rtl/ucic_pkg.sv
// types for the uart control and interrupt configuration block
package ucic_pkg;
  typedef struct packed {
    logic rx_section_enable;
    logic tx_section_enable;
    logic loopback_select;
    logic port_master_enable;
  } ucic_ctrl_t;
  typedef struct packed {
    logic [2:0] rx_trigger_level;
    logic [2:0] tx_trigger_level;
  } ucic_trig_t;
  typedef struct packed {
    logic overrun;
    logic break_error;
    logic parity_error;
    logic framing_error;
    logic rx_timeout;
  } ucic_err_t;
  typedef struct packed {
    logic overrun;
    logic break_error;
    logic parity_error;
    logic framing_error;
    logic rx_timeout;
    logic tx_level;
    logic rx_level;
  } ucic_irq_t;
endpackage

// >>> rtl/ucic_top.sv
// uart control, trigger level and interrupt mask logic on ahb-lite
`include "ucic_consts.svh"
module ucic_top #(
  parameter int DEPTH = 16,
  parameter int FW = $clog2(DEPTH + 1)
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ucic_pkg::ucic_err_t err_evt,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic [FW-1:0] tx_fill,
  input wire logic [FW-1:0] rx_fill,
  input wire logic tx_line,
  input wire logic serial_in,
  output logic serial_out,
  output logic rx_line,
  output logic tx_run,
  output logic rx_run,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // trigger code to eighths of the fifo, zero for reserved codes

  function automatic logic [3:0] ucic_eighths(input logic [2:0] code);
    logic [3:0] k;
    k = 4'h0;
    case (code)
      3'h0: k = 4'h1;
      3'h1: k = 4'h2;
      3'h2: k = 4'h4;
      3'h3: k = 4'h6;
      3'h4: k = 4'h7;
      default: k = 4'h0;
    endcase
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus and register state

  ucic_pkg::ucic_ctrl_t ctrl_r;
  ucic_pkg::ucic_ctrl_t ctrl_nxt;
  ucic_pkg::ucic_trig_t trig_r;
  ucic_pkg::ucic_trig_t trig_nxt;
  ucic_pkg::ucic_irq_t mask_r;
  ucic_pkg::ucic_irq_t mask_nxt;
  ucic_pkg::ucic_irq_t stat_r;
  ucic_pkg::ucic_irq_t stat_nxt;
  ucic_pkg::ucic_irq_t evt;
  ucic_pkg::ucic_irq_t clr;
  logic dp_wr_r;
  logic dp_wr_nxt;
  logic [11:0] dp_addr_r;
  logic [11:0] dp_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic ap_take;
  logic ap_map;
  logic ap_rd;
  logic rd_stat;

  ////////////////////////////////////////////////////////////////////////////
  // core control state

  logic tx_run_r;
  logic tx_run_nxt;
  logic rx_run_r;
  logic rx_run_nxt;
  logic serial_out_r;
  logic serial_out_nxt;
  logic rx_line_r;
  logic rx_line_nxt;
  logic rx_cond_r;
  logic tx_cond_r;
  logic rx_cond;
  logic tx_cond;
  logic tx_allow;
  logic rx_allow;
  logic [31:0] rx_lhs;
  logic [31:0] rx_rhs;
  logic [31:0] tx_lhs;
  logic [31:0] tx_rhs;

  ////////////////////////////////////////////////////////////////////////////
  // fifo level crossing detection

  always_comb
  begin
    rx_lhs = 32'(rx_fill) * 32'h8;
    tx_lhs = 32'(tx_fill) * 32'h8;
    rx_rhs = 32'(ucic_eighths(trig_r.rx_trigger_level)) * 32'(DEPTH);
    tx_rhs = 32'(ucic_eighths(trig_r.tx_trigger_level)) * 32'(DEPTH);
    // reserved codes never trigger
    rx_cond = (rx_rhs != 32'h0) && (rx_lhs >= rx_rhs);
    tx_cond = (tx_rhs != 32'h0) && (tx_lhs <= tx_rhs);
  end

  always_comb
  begin
    evt = '0;
    evt.overrun = err_evt.overrun;
    evt.break_error = err_evt.break_error;
    evt.parity_error = err_evt.parity_error;
    evt.framing_error = err_evt.framing_error;
    evt.rx_timeout = err_evt.rx_timeout;
    // edge, not level: a fill parked past the trigger fires once
    evt.rx_level = rx_cond & ~rx_cond_r;
    evt.tx_level = tx_cond & ~tx_cond_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  always_comb
  begin
    ap_take = hsel & hready & htrans[1];
    ap_map = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
    ap_rd = ap_take & ~hwrite & ap_map;
    rd_stat = ap_rd && (haddr[11:0] == `UCIC_OFF_STAT);
    dp_wr_nxt = ap_take & hwrite & ap_map;
    dp_addr_nxt = ap_take ? haddr[11:0] : dp_addr_r;
    ctrl_nxt = ctrl_r;
    trig_nxt = trig_r;
    mask_nxt = mask_r;
    if (dp_wr_r)
    begin
      case (dp_addr_r)
        `UCIC_OFF_CTRL:
        begin
          ctrl_nxt.rx_section_enable = hwdata[`UCIC_BIT_RXEN];
          ctrl_nxt.tx_section_enable = hwdata[`UCIC_BIT_TXEN];
          ctrl_nxt.loopback_select = hwdata[`UCIC_BIT_LOOP];
          ctrl_nxt.port_master_enable = hwdata[`UCIC_BIT_MASTER];
        end
        `UCIC_OFF_TRIG:
        begin
          trig_nxt.rx_trigger_level = hwdata[`UCIC_POS_RXTRIG +: 3];
          trig_nxt.tx_trigger_level = hwdata[`UCIC_POS_TXTRIG +: 3];
        end
        `UCIC_OFF_MASK: mask_nxt = hwdata[`UCIC_POS_IRQ +: 7];
        default: mask_nxt = mask_r;
      endcase
    end
    // read data built from the post-write value: a read right after a
    // write to the same register sees the new contents
    hrdata_nxt = hrdata_r;
    if (ap_rd)
    begin
      hrdata_nxt = 32'h0;
      case (haddr[11:0])
        `UCIC_OFF_CTRL:
        begin
          hrdata_nxt[`UCIC_BIT_RXEN] = ctrl_nxt.rx_section_enable;
          hrdata_nxt[`UCIC_BIT_TXEN] = ctrl_nxt.tx_section_enable;
          hrdata_nxt[`UCIC_BIT_LOOP] = ctrl_nxt.loopback_select;
          hrdata_nxt[`UCIC_BIT_MASTER] = ctrl_nxt.port_master_enable;
        end
        `UCIC_OFF_TRIG: hrdata_nxt[5:0] = trig_nxt;
        `UCIC_OFF_MASK: hrdata_nxt[`UCIC_POS_IRQ +: 7] = mask_nxt;
        `UCIC_OFF_STAT: hrdata_nxt[`UCIC_POS_IRQ +: 7] = stat_r;
        default: hrdata_nxt = 32'h0;
      endcase
    end
    // read clears, a fresh event in the same cycle survives
    clr = rd_stat ? stat_r : '0;
    stat_nxt = (stat_r & ~clr) | evt;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl_r.rx_section_enable <= `UCIC_RST_RXEN;
      ctrl_r.tx_section_enable <= `UCIC_RST_TXEN;
      ctrl_r.loopback_select <= `UCIC_RST_LOOP;
      ctrl_r.port_master_enable <= `UCIC_RST_MASTER;
      trig_r.rx_trigger_level <= `UCIC_RST_TRIG;
      trig_r.tx_trigger_level <= `UCIC_RST_TRIG;
      mask_r <= `UCIC_RST_MASK;
      stat_r <= '0;
      dp_wr_r <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata_r <= 32'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      trig_r <= trig_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      dp_wr_r <= dp_wr_nxt;
      dp_addr_r <= dp_addr_nxt;
      hrdata_r <= hrdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // run control and loopback routing

  always_comb
  begin
    tx_allow = ctrl_r.port_master_enable & ctrl_r.tx_section_enable;
    rx_allow = ctrl_r.port_master_enable & ctrl_r.rx_section_enable;
    // a running section only drops once its character is done
    tx_run_nxt = tx_allow | (tx_run_r & tx_busy);
    rx_run_nxt = rx_allow | (rx_run_r & rx_busy);
    // pin idles while looped so the far end sees no traffic
    serial_out_nxt = ctrl_r.loopback_select ? `UCIC_LINE_IDLE : tx_line;
    rx_line_nxt = ctrl_r.loopback_select ? tx_line : serial_in;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_run_r <= 1'b0;
      rx_run_r <= 1'b0;
      serial_out_r <= `UCIC_LINE_IDLE;
      rx_line_r <= `UCIC_LINE_IDLE;
      rx_cond_r <= 1'b0;
      tx_cond_r <= 1'b0;
    end
    else
    begin
      tx_run_r <= tx_run_nxt;
      rx_run_r <= rx_run_nxt;
      serial_out_r <= serial_out_nxt;
      rx_line_r <= rx_line_nxt;
      rx_cond_r <= rx_cond;
      tx_cond_r <= tx_cond;
    end
  end

  assign tx_run = tx_run_r;
  assign rx_run = rx_run_r;
  assign serial_out = serial_out_r;
  assign rx_line = rx_line_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_tx_stop_mid;
    tx_run_r && !tx_allow && tx_busy;
  endsequence

  sequence s_rx_stop_mid;
    rx_run_r && !rx_allow && rx_busy;
  endsequence

  sequence s_mask_read;
    ap_rd && (haddr[11:0] == `UCIC_OFF_MASK);
  endsequence

  a_tx_finish_char: assert property (s_tx_stop_mid |=> tx_run_r)
    else $error("transmitter stopped mid character");

  a_rx_finish_char: assert property (s_rx_stop_mid |=> rx_run_r)
    else $error("receiver stopped mid character");

  a_master_halt: assert property (
    !ctrl_r.port_master_enable && !tx_busy && !rx_busy
      |=> !tx_run_r && !rx_run_r)
    else $error("section kept running with master enable clear");

  a_run_needs_enable: assert property (
    $rose(tx_run_r) |-> $past(ctrl_r.port_master_enable))
    else $error("transmitter started without master enable");

  a_loop_route: assert property (
    ctrl_r.loopback_select |=> rx_line_r == $past(tx_line)
      && serial_out_r == `UCIC_LINE_IDLE)
    else $error("loopback did not route the transmit line");

  a_rx_cross_set: assert property (
    (rx_cond && !rx_cond_r) |=> stat_r.rx_level)
    else $error("receive level crossing not flagged");

  a_no_level_refire: assert property (
    (!stat_r.tx_level && tx_cond && tx_cond_r) |=> !stat_r.tx_level)
    else $error("transmit level flagged without a crossing");

  a_mask_readback: assert property (
    s_mask_read |=> hrdata[`UCIC_POS_IRQ +: 7] == mask_r)
    else $error("mask read did not return the stored value");

  a_irq_or_masked: assert property (
    irq == |(stat_r & mask_r))
    else $error("interrupt output disagrees with masked status");

  a_stat_read_clear: assert property (
    (rd_stat && evt == '0) |=> stat_r == '0)
    else $error("status read did not clear the status");

endmodule

// >>> verification/ucic_core_model.sv
// behavioural model of the transmit and receive cores beside the block
module ucic_core_model #(
  parameter int CHAR = 8
)
(
  input wire logic ref_clk,
  input wire logic start,
  input wire logic tx_run,
  input wire logic rx_run,
  output logic tx_busy,
  output logic rx_busy,
  output logic tx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic tx_b = 1'b0;
  logic rx_b = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // a character starts only in a section that runs
  always @(posedge ref_clk)
  begin
    if (cnt > 0)
      cnt <= cnt - 1;
    else if (start)
    begin
      cnt <= CHAR;
      tx_b <= tx_run;
      rx_b <= rx_run;
    end
  end
  assign tx_busy = tx_b && (cnt > 0);
  assign rx_busy = rx_b && (cnt > 0);
  // low for the whole character, so a looped line is easy to tell apart
  assign tx_line = ~tx_busy;
endmodule

// >>> verification/uart_control_and_irq_config_bench.sv
// self-checking bench for the control and interrupt configuration block
`include "ucic_consts.svh"
module uart_control_and_irq_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, serial_out, rx_line, tx_run, rx_run, irq;
  ucic_pkg::ucic_err_t err_evt = '0;
  logic [4:0] tx_fill = 5'h10;
  logic [4:0] rx_fill = 5'h0;
  logic serial_in = 1'b1;
  logic start = 1'b0;
  logic tx_busy, rx_busy, tx_line;
  logic [31:0] q;
  int n_fail = 0;
  int n_compared = 0;
  always #25 ref_clk = ~ref_clk;
  ucic_top #(.DEPTH(16)) uut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .err_evt(err_evt),
    .tx_busy(tx_busy), .rx_busy(rx_busy), .tx_fill(tx_fill),
    .rx_fill(rx_fill), .tx_line(tx_line), .serial_in(serial_in),
    .serial_out(serial_out), .rx_line(rx_line), .tx_run(tx_run),
    .rx_run(rx_run), .irq(irq));
  ucic_core_model core (.ref_clk(ref_clk), .start(start), .tx_run(tx_run),
    .rx_run(rx_run), .tx_busy(tx_busy), .rx_busy(rx_busy),
    .tx_line(tx_line));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic hang();
    n_fail++;
    $display("timeout");
    results();
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 100)
        hang();
      @(posedge ref_clk);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic rd_chk(string what, logic [11:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(what, q, e);
  endtask
  // master enable goes off before any new configuration
  task automatic cfg(logic [31:0] v);
    xfer(1'b1, `UCIC_OFF_CTRL, 32'h0);
    xfer(1'b1, `UCIC_OFF_CTRL, v);
  endtask
  task automatic char_go();
    start <= 1'b1;
    wt(1);
    start <= 1'b0;
    wt(3);
  endtask
  task automatic idle();
    int k;
    for (k = 0; k < 20 && (tx_busy || rx_busy); k++)
      wt(1);
    if (k == 20)
      hang();
    wt(2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk("ctrl", `UCIC_OFF_CTRL, 32'h300);
    rd_chk("trig", `UCIC_OFF_TRIG, 32'h12);
    rd_chk("mask", `UCIC_OFF_MASK, 32'h0);
    rd_chk("unmapped", 12'h040, 32'h0);
    chk("okay resp", hresp, 1'b0);
    chk("run idle", {tx_run, rx_run}, 2'h0);
  endtask
  task automatic t_irq();
    xfer(1'b1, `UCIC_OFF_MASK, 32'h7F0);
    rd_chk("mask rb", `UCIC_OFF_MASK, 32'h7F0);
    for (int i = 0; i < 6; i++)
    begin
      // last pass repeats rx timeout with its mask bit cleared
      if (i == 5)
        xfer(1'b1, `UCIC_OFF_MASK, 32'h7B0);
      err_evt <= ucic_pkg::ucic_err_t'(5'h1 << (i % 5));
      wt(1);
      err_evt <= '0;
      wt(2);
      chk("irq on", irq, i < 5);
      rd_chk("status", `UCIC_OFF_STAT, 32'h40 << (i % 5));
      wt(1);
      chk("irq off", irq, 1'b0);
    end
  endtask
  task automatic t_trig();
    int thr[6] = '{2, 4, 8, 12, 14, 8};
    for (int c = 0; c < 6; c++)
    begin
      xfer(1'b1, `UCIC_OFF_TRIG, {26'h0, 3'(c), 3'(c)});
      rx_fill <= 5'(thr[c] - 1);
      tx_fill <= 5'(thr[c] + 1);
      wt(2);
      xfer(1'b0, `UCIC_OFF_STAT, 32'h0);
      rx_fill <= 5'(thr[c]);
      tx_fill <= 5'(thr[c]);
      wt(2);
      rd_chk("cross", `UCIC_OFF_STAT, c < 5 ? 32'h30 : 32'h0);
      rx_fill <= 5'(thr[c] + 1);
      tx_fill <= 5'(thr[c] - 1);
      wt(2);
      rd_chk("beyond", `UCIC_OFF_STAT, 32'h0);
    end
    rx_fill <= 5'h0;
    tx_fill <= 5'h10;
  endtask
  task automatic t_run();
    logic [31:0] v[5] = '{32'h301, 32'h201, 32'h101, 32'h1, 32'h300};
    logic [1:0] e[5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h0};
    for (int i = 0; i < 5; i++)
    begin
      cfg(v[i]);
      wt(2);
      chk("run", {tx_run, rx_run}, e[i]);
    end
  endtask
  task automatic t_stop();
    logic [31:0] v[3] = '{32'h300, 32'h201, 32'h101};
    logic [1:0] e[3] = '{2'h0, 2'h1, 2'h2};
    for (int i = 0; i < 3; i++)
    begin
      cfg(32'h301);
      wt(2);
      start <= 1'b1;
      wt(1);
      start <= 1'b0;
      xfer(1'b1, `UCIC_OFF_CTRL, v[i]);
      wt(2);
      chk("finishing", {tx_run, rx_run}, 2'h3);
      idle();
      chk("stopped", {tx_run, rx_run}, e[i]);
    end
  endtask
  task automatic t_loop();
    cfg(32'h381);
    wt(2);
    char_go();
    chk("loop rx", rx_line, 1'b0);
    chk("loop tx", serial_out, 1'b1);
    idle();
    cfg(32'h301);
    wt(2);
    char_go();
    chk("line rx", rx_line, 1'b1);
    chk("line tx", serial_out, 1'b0);
    idle();
    serial_in <= 1'b0;
    wt(2);
    chk("pin rx", rx_line, 1'b0);
    serial_in <= 1'b1;
    wt(2);
  endtask
  initial
  begin
    wt(16);
    reset <= 1'b0;
    wt(1);
    t_reset();
    t_irq();
    t_trig();
    t_run();
    t_stop();
    t_loop();
    results();
  end
endmodule
